/* File: logic/spi_host_pkg.sv */
// Functional notes
// - Classic format is full duplex; select low across frames, high when idle.
// - Clock idles low for polarity 0, high for polarity 1.
// - Phase 0 samples on the leading edge, phase 1 on the trailing edge.
// - Modes 0 and 3 launch falling, capture rising; modes 1 and 2 reverse.
// - Pulse-framed select is a one-bit-period high pulse starting each frame.
// - Pulse-framed format uses mode 1 only: launch rising, capture falling.
// - Back-to-back preceding pulse coincides with the last bit, leaving no gap.
// - Half-duplex alternates transmit and receive with independent widths.
// - Half-duplex: one idle bit before receive; consecutive transfers without gap.
// - Half-duplex uses mode 0 only, clock idling low.
// - After wake-up the slave sends 0xFF; master treats it as not ready.
// - Frame width 4 to 16 bits, default 8; MSb or LSb first.
package spi_host_pkg;

  // ----------------------------------------------------------------
  // Controller register map
  // ----------------------------------------------------------------
  localparam logic [7:0]  CTRL_OFF    = 8'h00;
  localparam logic [7:0]  TXDATA_OFF  = 8'h04;
  localparam logic [7:0]  RXDATA_OFF  = 8'h08;
  localparam logic [7:0]  STATUS_OFF  = 8'h0c;

  localparam int FMT_LSB       = 0;
  localparam int CPHA_BIT      = 2;
  localparam int CPOL_BIT      = 3;
  localparam int PRECEDE_BIT   = 4;
  localparam int LSB_FIRST_BIT = 5;
  localparam int WIDTH_LSB     = 8;
  localparam int RXW_LSB       = 16;
  localparam int DIV_LSB       = 24;

  localparam logic [31:0] CTRL_RESET = 32'h04080800;

  localparam int STAT_BUSY = 0;
  localparam int STAT_PEND = 1;
  localparam int STAT_RXV  = 2;
  localparam int STAT_NRDY = 3;

  // ----------------------------------------------------------------
  // Frame formats, same codes as the device
  // ----------------------------------------------------------------
  localparam logic [1:0] FMT_CLASSIC = 2'h0;
  localparam logic [1:0] FMT_PULSE   = 2'h1;
  localparam logic [1:0] FMT_HALF    = 2'h2;

  // ----------------------------------------------------------------
  // Device map, for software setting up the far end
  // ----------------------------------------------------------------
  localparam int         DEV_BLOCK_MODE_LSB = 24;
  localparam logic [1:0] DEV_BLOCK_MODE_SPI = 2'h1;
  localparam int         DEV_FMT_LSB        = 24;
  localparam int         DEV_PRECEDE_BIT    = 1;
  localparam int         DEV_CPHA_BIT       = 2;
  localparam int         DEV_CPOL_BIT       = 3;

  // ----------------------------------------------------------------
  // Limits and timing
  // ----------------------------------------------------------------
  localparam logic [4:0] WIDTH_MIN      = 5'h04;
  localparam logic [4:0] WIDTH_MAX      = 5'h10;
  localparam logic [7:0] HALF_DIV_MIN   = 8'h04;
  localparam logic [7:0] NOT_READY_BYTE = 8'hff;

  typedef enum logic [2:0] {S_IDLE, S_PRE, S_TX, S_GAP, S_RX} state_e;

endpackage

/* File: logic/spi_host.sv */
// The register addresses and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
module spi_host
  import spi_host_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  // APB slave
  input  wire logic [7:0]  paddr_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // SPI link
  output logic             sclk_o,
  output logic             mosi_o,
  output logic             select_o,
  input  wire logic        miso_i
);

  typedef struct packed {
    state_e      st;
    logic [31:0] ctrl;
    logic [15:0] txbuf;
    logic        pend;
    logic [15:0] txsh;
    logic [15:0] rxsh;
    logic [15:0] rxdata;
    logic        rxv;
    logic        nrdy;
    logic [4:0]  cnt;
    logic        half;
    logic [7:0]  hcnt;
    logic        sclk;
    logic        mosi;
    logic        ss;
    logic [2:0]  msync;
    logic        miso;
    logic        ack;
    logic        err;
    logic [31:0] prdata;
    logic [8:0]  ss_hi;
  } state_s;

  state_s r_reg;
  state_s r_next;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [4:0] clamp_w(input logic [4:0] w);
    if (w < WIDTH_MIN) begin
      return WIDTH_MIN;
    end else if (w > WIDTH_MAX) begin
      return WIDTH_MAX;
    end
    return w;
  endfunction

  function automatic logic [3:0] bit_idx(input logic lsb, input logic [4:0] w,
                                         input logic [4:0] c);
    if (lsb) begin
      return c[3:0];
    end
    return 4'(w - 5'h01 - c);
  endfunction

  logic [1:0]  fmt;
  logic        eff_cpol;
  logic        eff_cpha;
  logic        precede;
  logic        lsb_first;
  logic [4:0]  txw;
  logic [4:0]  rxw;
  logic [4:0]  wcur;
  logic [7:0]  half_div;
  logic        idle_ss;
  logic        acc;
  logic        adv;
  logic        samp;
  logic        fin;
  logic        start;
  logic        last;
  logic        cont;
  logic [15:0] v_rx;
  logic [15:0] v_mask;
  logic [31:0] v_stat;

  always_comb begin
    fmt       = r_reg.ctrl[FMT_LSB +: 2];
    precede   = r_reg.ctrl[PRECEDE_BIT];
    lsb_first = r_reg.ctrl[LSB_FIRST_BIT];
    // Pulse framing forces mode 1, half duplex forces mode 0
    eff_cpol  = (fmt == FMT_CLASSIC) ? r_reg.ctrl[CPOL_BIT] : 1'b0;
    eff_cpha  = (fmt == FMT_CLASSIC) ? r_reg.ctrl[CPHA_BIT] : (fmt == FMT_PULSE);
    txw       = clamp_w(r_reg.ctrl[WIDTH_LSB +: 5]);
    rxw       = clamp_w(r_reg.ctrl[RXW_LSB +: 5]);
    half_div  = (r_reg.ctrl[DIV_LSB +: 8] < HALF_DIV_MIN) ? HALF_DIV_MIN
                                                          : r_reg.ctrl[DIV_LSB +: 8];
    idle_ss   = (fmt != FMT_PULSE);
    wcur      = (r_reg.st == S_RX) ? rxw : txw;
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    r_next = r_reg;
    adv    = 1'b0;
    samp   = 1'b0;
    fin    = 1'b0;
    start  = 1'b0;
    last   = 1'b0;
    cont   = 1'b0;
    v_rx   = r_reg.rxsh;
    v_mask = 16'((32'h1 << wcur) - 32'h1);
    v_stat = '0;

    // Three-stage input sync; a change counts once stages two and three agree
    r_next.msync = {r_reg.msync[1:0], miso_i};
    if (r_reg.msync[1] == r_reg.msync[2]) begin
      r_next.miso = r_reg.msync[2];
    end

    case (r_reg.st)
      S_IDLE: begin
        r_next.sclk = eff_cpol;
        r_next.ss   = idle_ss;
        r_next.mosi = 1'b0;
        if (r_reg.pend) begin
          r_next.txsh = r_reg.txbuf;
          r_next.pend = 1'b0;
          r_next.rxsh = '0;
          r_next.cnt  = '0;
          r_next.st   = (fmt == FMT_PULSE && precede) ? S_PRE : S_TX;
          start       = 1'b1;
        end
      end
      default: begin
        r_next.hcnt = r_reg.hcnt + 8'h01;
        if (r_reg.hcnt == half_div - 8'h01) begin
          r_next.hcnt = '0;
          if (!r_reg.half) begin
            r_next.half = 1'b1;
            r_next.sclk = eff_cpol ^ ~eff_cpha;
          end else begin
            adv = 1'b1;
          end
        end
      end
    endcase

    if (adv) begin
      // Sample at bit end; the sync delay keeps the mid-bit edge value
      samp = (r_reg.st == S_TX && fmt != FMT_HALF) || r_reg.st == S_RX;
      if (samp) begin
        v_rx[bit_idx(lsb_first, wcur, r_reg.cnt)] = r_reg.miso;
      end
      r_next.rxsh = v_rx;
      last  = (r_reg.cnt == wcur - 5'h01);
      start = 1'b1;
      case (r_reg.st)
        S_PRE: begin
          r_next.st  = S_TX;
          r_next.cnt = '0;
        end
        S_TX: begin
          if (!last) begin
            r_next.cnt = r_reg.cnt + 5'h01;
          end else if (fmt == FMT_HALF) begin
            r_next.st = S_GAP;
          end else begin
            fin = 1'b1;
          end
        end
        S_GAP: begin
          r_next.st  = S_RX;
          r_next.cnt = '0;
        end
        default: begin
          if (!last) begin
            r_next.cnt = r_reg.cnt + 5'h01;
          end else begin
            fin = 1'b1;
          end
        end
      endcase
    end

    if (fin) begin
      r_next.rxdata = v_rx & v_mask;
      r_next.rxv    = 1'b1;
      r_next.nrdy   = (wcur >= 5'h08) &&
                      ((v_rx[bit_idx(1'b1, wcur, 5'h00) +: 8] & NOT_READY_BYTE)
                       == NOT_READY_BYTE) && ((v_rx & v_mask) == v_mask);
      // Without the early pulse a preceded frame must restart through its pulse
      cont = r_reg.pend && !(fmt == FMT_PULSE && precede && !r_reg.ss);
      if (cont) begin
        r_next.txsh = r_reg.txbuf;
        r_next.pend = 1'b0;
        r_next.rxsh = '0;
        r_next.cnt  = '0;
        r_next.st   = S_TX;
      end else begin
        r_next.st   = S_IDLE;
        start       = 1'b0;
        r_next.sclk = eff_cpol;
        r_next.ss   = idle_ss;
        r_next.mosi = 1'b0;
        r_next.half = 1'b0;
      end
    end

    if (start) begin
      r_next.half = 1'b0;
      r_next.hcnt = '0;
      r_next.sclk = eff_cpol ^ eff_cpha;
      r_next.mosi = (r_next.st == S_TX) ?
                    r_next.txsh[bit_idx(lsb_first, txw, r_next.cnt)] : 1'b0;
      if (fmt == FMT_PULSE) begin
        r_next.ss = (r_next.st == S_PRE) ||
                    (r_next.st == S_TX && !precede && r_next.cnt == 5'h00) ||
                    (r_next.st == S_TX && precede && r_next.cnt == txw - 5'h01 &&
                     r_next.pend);
      end else begin
        r_next.ss = 1'b0;
      end
    end

    // APB: one wait state; a data write waits while the holding slot is full
    acc         = psel_i & penable_i;
    r_next.ack  = 1'b0;
    if (acc && !r_reg.ack) begin
      if (!(pwrite_i && paddr_i == TXDATA_OFF && r_reg.pend)) begin
        r_next.ack    = 1'b1;
        r_next.err    = 1'b0;
        r_next.prdata = '0;
        v_stat[STAT_BUSY] = (r_reg.st != S_IDLE);
        v_stat[STAT_PEND] = r_reg.pend;
        v_stat[STAT_RXV]  = r_reg.rxv;
        v_stat[STAT_NRDY] = r_reg.nrdy;
        if (paddr_i == CTRL_OFF) begin
          r_next.prdata = r_reg.ctrl;
          r_next.err    = pwrite_i && (r_reg.st != S_IDLE || r_reg.pend);
        end else if (paddr_i == TXDATA_OFF) begin
          r_next.prdata = {16'h0000, r_reg.txbuf};
        end else if (paddr_i == RXDATA_OFF) begin
          r_next.prdata = {16'h0000, r_reg.rxdata};
        end else if (paddr_i == STATUS_OFF) begin
          r_next.prdata = v_stat;
        end else begin
          r_next.err    = 1'b1;
        end
      end
    end
    if (acc && r_reg.ack && !r_reg.err) begin
      if (pwrite_i && paddr_i == CTRL_OFF) begin
        r_next.ctrl = pwdata_i;
      end else if (pwrite_i && paddr_i == TXDATA_OFF) begin
        r_next.txbuf = pwdata_i[15:0];
        r_next.pend  = 1'b1;
      end else if (!pwrite_i && paddr_i == RXDATA_OFF && !fin) begin
        // A frame landing in the same cycle keeps its flag
        r_next.rxv = 1'b0;
      end
    end

    r_next.ss_hi = (r_next.ss && fmt == FMT_PULSE) ? r_reg.ss_hi + 9'h001 : 9'h000;
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      r_reg      <= '0;
      r_reg.st   <= S_IDLE;
      r_reg.ctrl <= CTRL_RESET;
      r_reg.ss   <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  assign prdata_o  = r_reg.prdata;
  assign pready_o  = r_reg.ack;
  assign pslverr_o = r_reg.err;
  assign sclk_o    = r_reg.sclk;
  assign mosi_o    = r_reg.mosi;
  assign select_o  = r_reg.ss;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  sequence s_idle2;
    (r_reg.st == S_IDLE)[*2];
  endsequence

  sequence s_slot_end;
    r_reg.st != S_IDLE && r_reg.half && r_reg.hcnt == half_div - 8'h01;
  endsequence

  a_idle_clock_level: assert property (
    s_idle2 ##0 $stable(r_reg.ctrl) |-> sclk_o == (r_reg.ctrl[CPOL_BIT] && fmt == FMT_CLASSIC))
    else $error("clock not at idle polarity");

  a_idle_select_high: assert property (
    s_idle2 ##0 (fmt != FMT_PULSE && $past(fmt) != FMT_PULSE) |-> select_o)
    else $error("select not high while idle");

  a_classic_select_low: assert property (
    (r_reg.st != S_IDLE && fmt != FMT_PULSE) |-> !select_o)
    else $error("select high during a frame");

  a_pulse_one_bit: assert property (
    (fmt == FMT_PULSE && $fell(select_o) && $past(r_reg.st) != S_IDLE) |->
    $past(r_reg.ss_hi) == 9'(2 * half_div))
    else $error("frame pulse not one bit period");

  a_pulse_mode_one: assert property (
    (fmt == FMT_PULSE && r_reg.st != S_IDLE && $rose(sclk_o)) |-> !r_reg.half)
    else $error("pulse format not in mode 1");

  a_half_mode_zero: assert property (
    (fmt == FMT_HALF && r_reg.st != S_IDLE) |-> (sclk_o == r_reg.half))
    else $error("half duplex not in mode 0");

  a_launch_slot_start: assert property (
    (r_reg.st != S_IDLE && $changed(mosi_o) && $past(r_reg.st) != S_IDLE)
    |-> !r_reg.half && r_reg.hcnt == 8'h00)
    else $error("data launched mid bit");

  a_sample_late_half: assert property (
    samp |-> r_reg.half && sclk_o == (eff_cpol ^ ~eff_cpha))
    else $error("sample outside second half");

  a_half_one_gap: assert property (
    (r_reg.st == S_GAP) ##0 s_slot_end |=> r_reg.st == S_RX ##1 !r_reg.half [*1])
    else $error("idle bit not followed by receive");

  a_not_ready_flag: assert property (
    (fin && wcur == 5'h08 && v_rx[7:0] == NOT_READY_BYTE) |=> r_reg.nrdy && r_reg.rxv)
    else $error("all-ones byte not flagged");

  a_apb_ready_phase: assert property (
    pready_o |-> $past(psel_i && penable_i))
    else $error("ready outside an access");

endmodule

/* File: verif/spi_dev_model.sv */
`timescale 1ns/1ps
module spi_dev_model (
  // Link
  input  wire logic        sclk_i,
  input  wire logic        mosi_i,
  input  wire logic        select_i,
  output logic             miso_o,
  // Setup
  input  wire logic [1:0]  fmt_i,
  input  wire logic        cpol_i,
  input  wire logic        cpha_i,
  input  wire logic        lsb_i,
  input  wire logic [4:0]  width_i,
  input  wire logic [15:0] reply_i,
  input  wire logic        nrdy_i,
  input  wire logic        pre_i
);
  logic [15:0] word;
  logic [15:0] rx_q[$];
  int          n_cap;
  logic        pol;
  logic        pha;
  logic        bit_q = 1'b0;

  // ----------------------------------------------------------------
  // Slave side of the link
  // ----------------------------------------------------------------
  assign pol = (fmt_i == 2'h0) && cpol_i;
  assign pha = (fmt_i == 2'h1) || ((fmt_i == 2'h0) && cpha_i);
  // Deselected line shows the inverse, so a late sample never matches
  assign miso_o = nrdy_i | ((fmt_i != 2'h1 && select_i) ? ~bit_q : bit_q);

  function automatic int pos(int i);
    return lsb_i ? i % width_i : width_i - 1 - i % width_i;
  endfunction

  task automatic clear();
    n_cap = 0;
    word = 16'h0000;
    rx_q.delete();
  endtask

  always @(negedge select_i) begin
    if (fmt_i != 2'h1 && !pha)
      bit_q = reply_i[pos(n_cap)];
  end

  // Wraps to the first bit position (bit 0 LSb first, bit width-1 MSb first) at frame end, so back-to-back frames need no select edge
  always @(sclk_i) begin
    if ((sclk_i != pol) != pha) begin
      // A preceding pulse at a frame boundary marks a slot with no data
      if (!(fmt_i == 2'h1 && pre_i && select_i && n_cap % width_i == 0)) begin
        if (!nrdy_i)
          word[pos(n_cap)] = mosi_i;
        n_cap++;
        if (n_cap % width_i == 0) begin
          rx_q.push_back(word);
          word = 16'h0000;
        end
      end
    end else
      bit_q = reply_i[pos(n_cap)];
  end
endmodule

/* File: verif/testbench.sv */
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin n_fail++; \
  $display("CHECK FAILED %s exp %h got %h", nm, (exp), (got)); end end
module testbench;
  import spi_host_pkg::*;
  logic        clk_i = 1'b0, rstn_i = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, sclk, mosi, sel, miso, err, sel_q = 1'b1, sclk_q = 1'b0;
  logic [1:0]  m_fmt = 2'h0;
  logic        m_cpol = 1'b0, m_cpha = 1'b0, m_lsb = 1'b0, m_nr = 1'b0, m_pre = 1'b0;
  logic [4:0]  m_w = 5'h08;
  logic [15:0] m_rp = 16'h0000;
  int          n_fail = 0, cmp_count = 0, cyc = 0, run = 0, lo_len = 0, hi_len = 0;
  int          n_rise = 0, t_rise = 0, rise_gap = 0, n_sclk = 0, n0;
  logic [4:0]  wt[4] = '{5'h08, 5'h04, 5'h10, 5'h0c};
  logic [15:0] txt[4] = '{16'h00a5, 16'h0009, 16'hc35a, 16'h0b6d};
  logic [15:0] rpt[4] = '{16'h003c, 16'h0006, 16'h96e1, 16'h0e12};

  always #25 clk_i = ~clk_i;

  spi_host u_dut (.clk_i(clk_i), .rstn_i(rstn_i), .paddr_i(paddr), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .sclk_o(sclk), .mosi_o(mosi),
    .select_o(sel), .miso_i(miso));
  spi_dev_model u_dev (.sclk_i(sclk), .mosi_i(mosi), .select_i(sel), .miso_o(miso),
    .fmt_i(m_fmt), .cpol_i(m_cpol), .cpha_i(m_cpha), .lsb_i(m_lsb), .width_i(m_w),
    .reply_i(m_rp), .nrdy_i(m_nr), .pre_i(m_pre));

  // ----------------------------------------------------------------
  // Link monitor: run lengths of select and pulse timing
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    cyc++;
    if (sel !== sel_q) begin
      if (sel_q === 1'b0)
        lo_len = run;
      else
        hi_len = run;
      if (sel === 1'b1) begin
        n_rise++;
        rise_gap = cyc - t_rise;
        t_rise = cyc;
      end
      run = 0;
    end
    if (sclk === 1'b1 && sclk_q === 1'b0)
      n_sclk++;
    run++;
    sel_q = sel;
    sclk_q = sclk;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  function automatic logic [15:0] mk(input logic [4:0] w);
    return 16'((17'h1 << w) - 17'h1);
  endfunction

  task automatic complete_run();
    $display("checks %0d failures %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready !== 1'b1 && n < 4000);
    if (n >= 4000) begin
      n_fail++;
      complete_run();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Polls status until the engine holds no word and is not shifting
  task automatic idle();
    int n = 0;
    do begin
      apb(1'b0, STATUS_OFF, 32'h0);
      n++;
    end while ((rd[STAT_BUSY] | rd[STAT_PEND]) !== 1'b0 && n < 300);
    if (n >= 300) begin
      n_fail++;
      complete_run();
    end
  endtask

  task automatic xfer(input logic [1:0] f, input logic ph, po, pr, ls,
                      input logic [4:0] w, rw, input logic [15:0] tx, rp, input int nw);
    logic [31:0] c;
    c = {8'h04, 3'h0, rw, 3'h0, w, 2'h0, ls, pr, po, ph, f};
    m_fmt = f;
    m_cpol = po;
    m_cpha = ph;
    m_lsb = ls;
    m_pre = pr;
    m_w = w;
    m_rp = rp;
    u_dev.clear();
    apb(1'b1, CTRL_OFF, c);
    `CHK("ctrl_err", 1'b0, err)
    repeat (nw) apb(1'b1, TXDATA_OFF, {16'h0, tx});
    if (nw > 1) begin
      apb(1'b1, CTRL_OFF, c);
      `CHK("ctrl_busy_err", 1'b1, err)
    end
    idle();
    apb(1'b0, RXDATA_OFF, 32'h0);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk_i);
    rstn_i <= 1'b1;
    @(posedge clk_i);
    apb(1'b0, CTRL_OFF, 32'h0);
    `CHK("ctrl_reset", CTRL_RESET, rd)
    `CHK("reset_sclk", 1'b0, sclk)
    `CHK("reset_select", 1'b1, sel)
    apb(1'b0, 8'h10, 32'h0);
    `CHK("unmapped_err", 1'b1, err)
    `CHK("unmapped_data", 32'h0, rd)
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      xfer(FMT_CLASSIC, i[0], i[1], 1'b0, i == 2, wt[i], 5'h0, txt[i], rpt[i], 1);
      `CHK("mode_rx", rpt[i] & mk(wt[i]), rd[15:0])
      `CHK("mode_tx", txt[i] & mk(wt[i]), u_dev.rx_q[0])
      `CHK("mode_sclk_idle", i[1], sclk)
      `CHK("mode_select_idle", 1'b1, sel)
      `CHK("mode_frame_len", 8 * int'(wt[i]), lo_len)
    end
    $display("test clock modes done");
    n0 = n_rise;
    xfer(FMT_CLASSIC, 1'b0, 1'b0, 1'b0, 1'b0, 5'h08, 5'h0, 16'h00c3, 16'h0081, 2);
    `CHK("b2b_rises", n0 + 1, n_rise)
    `CHK("b2b_len", 128, lo_len)
    `CHK("b2b_second", 16'h00c3, u_dev.rx_q[1])
    $display("test back to back done");
    for (int p = 0; p < 2; p++) begin
      n_sclk = 0;
      xfer(FMT_PULSE, 1'b0, 1'b1, p[0], 1'b0, 5'h08, 5'h0, 16'h0096, 16'h00e4, 2);
      `CHK("pulse_width", 8, hi_len)
      `CHK("pulse_lead", (p == 1) ? 17 : 16, n_sclk)
      `CHK("pulse_tx", 16'h0096, u_dev.rx_q[1])
      `CHK("pulse_rx", 16'h00e4, rd[15:0])
      `CHK("pulse_sclk", 1'b0, sclk)
      if (p == 1)
        `CHK("pulse_gap", 64, rise_gap)
    end
    $display("test pulse format done");
    xfer(FMT_HALF, 1'b1, 1'b1, 1'b0, 1'b0, 5'h08, 5'h04, 16'h005b, 16'hffff, 2);
    `CHK("half_rx", 16'h000f, rd[15:0])
    `CHK("half_tx", 16'h005b, u_dev.rx_q[0])
    `CHK("half_len", 208, lo_len)
    `CHK("half_sclk", 1'b0, sclk)
    $display("test half duplex done");
    m_nr = 1'b1;
    xfer(FMT_CLASSIC, 1'b0, 1'b0, 1'b0, 1'b0, 5'h08, 5'h0, 16'h0011, 16'h0000, 1);
    `CHK("nrdy_rx", 16'h00ff, rd[15:0])
    apb(1'b0, STATUS_OFF, 32'h0);
    `CHK("nrdy_flag", 1'b1, rd[STAT_NRDY])
    `CHK("rxv_cleared", 1'b0, rd[STAT_RXV])
    m_nr = 1'b0;
    xfer(FMT_CLASSIC, 1'b0, 1'b0, 1'b0, 1'b0, 5'h08, 5'h0, 16'h0011, 16'h005a, 1);
    `CHK("ready_rx", 16'h005a, rd[15:0])
    apb(1'b0, STATUS_OFF, 32'h0);
    `CHK("ready_flag", 1'b0, rd[STAT_NRDY])
    $display("test not ready done");
    complete_run();
  end
endmodule
